// ### odm_pkg.sv
// package for the fuse default memory block
package odm_pkg;
    localparam logic [31:0] ADDR_FUSE_READBACK = 32'h0000_0005;
    localparam logic [31:0] ADDR_PROGRAM       = 32'h0000_0010;
    localparam logic [31:0] ADDR_DRIVE_CFG     = 32'h0000_0020;
    localparam logic [31:0] ADDR_SINGLE_LINE   = 32'h0000_0018;
    localparam logic [31:0] ADDR_DEAD_STATUS   = 32'h0000_001c;
    localparam int          ADDR_BYTE_SCALE    = 4;
    localparam int          DT_POS             = 6;
    localparam int          SHORT_POS          = 5;
    localparam int          TRIM_POS           = 0;
    localparam int          TRIM_W             = 5;
    localparam logic [7:0]  FUSE_BLANK         = 8'h00;
    localparam logic [3:0]  DT_CODE0_CYCLES    = 4'h4;
    localparam logic [3:0]  SHORT_LEVEL_LOW    = 4'h6;
    localparam logic [3:0]  SHORT_LEVEL_HIGH   = 4'hc;
    localparam logic [4:0]  FACTORY_TRIM       = 5'h10;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;

    typedef struct packed {
        logic [3:0] dead_time_cycles;
        logic [3:0] highside_ground_fault_level;
        logic [3:0] lowside_supply_fault_level;
        logic [4:0] oscillator_trim_code;
    } odm_cfg_t;

    typedef enum logic [1:0] {ST_LOAD, ST_RUN} odm_state_t;
endpackage : odm_pkg

// ### odm_fuse_array.sv
// one-time-programmable fuse byte, set-only cells
`timescale 1ns/1ps
module odm_fuse_array #(
    parameter logic [4:0] FACTORY_TRIM = odm_pkg::FACTORY_TRIM
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       prog_en,
    input  wire logic [7:0] prog_mask,
    output logic      [7:0] fuse_q
);
    // power-up contents: blank cells read zero, factory trim in the low bits
    logic [7:0] cell_q = {odm_pkg::FUSE_BLANK[7:5], FACTORY_TRIM};
    logic [7:0] fuse_d;

    // only ones can be burnt; nothing burns while reset is held
    always_comb begin
        fuse_d = cell_q;
        if (prog_en && hresetn) begin
            fuse_d = cell_q | prog_mask;
        end
    end

    // cells carry no reset: a bus reset must never unburn a fuse
    always_ff @(posedge hclk) begin
        cell_q <= fuse_d;
    end

    assign fuse_q = cell_q;

    // once set, a fuse never drops
    a_fuse_never_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        ((fuse_q & ~$past(fuse_q)) == (fuse_q ^ $past(fuse_q))))
        else $error("fuse bit cleared");
endmodule : odm_fuse_array

// ### odm_top.sv
// fuse default memory with ahb-lite register access
// Operation
// - 8-bit read-only fuse readback register at word 0x05, byte address 0x14
// - unprogrammed fuse bits read as zero
// - programming only sets fuse bits, never clears them
// - low five fuse bits carry factory oscillator trim
// - bits 7:6 pick dead time: 0 gives four, else code clocks
// - bit 5 sets both short levels to 6 or 12
// - bits 4:0 give oscillator trim, 0 lowest, 31 highest
// - dead time counted in clocks, only with single-line control
`timescale 1ns/1ps
module odm_top #(
    parameter logic [4:0] FACTORY_TRIM = odm_pkg::FACTORY_TRIM
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        gate_request,
    output logic             gate_high,
    output logic             gate_low,
    output odm_pkg::odm_cfg_t cfg,
    output logic             cfg_valid
);
    logic [7:0]          fuse_q;
    logic                prog_en;
    logic [7:0]          prog_mask;
    odm_pkg::odm_state_t state_q;
    logic                wr_q;
    logic [31:0]         addr_q;
    logic                single_line_q;
    logic [3:0]          dt_cnt_q;
    logic                gate_req_q;
    logic [3:0]          dt_default;
    logic [3:0]          short_default;

    odm_fuse_array #(.FACTORY_TRIM(FACTORY_TRIM)) u_fuse (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .prog_en   (prog_en),
        .prog_mask (prog_mask),
        .fuse_q    (fuse_q)
    );

    // fuse decode into defaults
    always_comb begin
        dt_default = (fuse_q[odm_pkg::DT_POS +: 2] == 2'h0) ? odm_pkg::DT_CODE0_CYCLES
                   : {2'h0, fuse_q[odm_pkg::DT_POS +: 2]};
        short_default = fuse_q[odm_pkg::SHORT_POS] ? odm_pkg::SHORT_LEVEL_HIGH
                      : odm_pkg::SHORT_LEVEL_LOW;
    end

    // ahb address phase capture; slave never waits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            addr_q <= 32'h0000_0000;
        end else if (hready) begin
            wr_q   <= hsel && htrans == odm_pkg::HTRANS_NONSEQ && hwrite;
            addr_q <= haddr;
        end
    end

    // fuse programming write; only ones are burnt, trim writes allowed but discouraged
    assign prog_en   = wr_q && addr_q == odm_pkg::ADDR_PROGRAM && state_q == odm_pkg::ST_RUN;
    assign prog_mask = hwdata[7:0];

    // reset loads the fuse defaults once, then software may tune
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= odm_pkg::ST_LOAD;
            cfg       <= '0;
            cfg_valid <= 1'b0;
        end else begin
            case (state_q)
                odm_pkg::ST_LOAD: begin
                    cfg.dead_time_cycles            <= dt_default;
                    cfg.highside_ground_fault_level <= short_default;
                    cfg.lowside_supply_fault_level  <= short_default;
                    cfg.oscillator_trim_code        <= fuse_q[odm_pkg::TRIM_POS +: odm_pkg::TRIM_W];
                    cfg_valid <= 1'b1;
                    state_q   <= odm_pkg::ST_RUN;
                end
                odm_pkg::ST_RUN: begin
                    if (wr_q && addr_q == odm_pkg::ADDR_DRIVE_CFG) begin
                        cfg <= hwdata[16:0];
                    end
                end
                default: state_q <= odm_pkg::ST_LOAD;
            endcase
        end
    end

    // single-line mode select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            single_line_q <= 1'b0;
        end else if (wr_q && addr_q == odm_pkg::ADDR_SINGLE_LINE) begin
            single_line_q <= hwdata[0];
        end
    end

    // dead time: both gates off for dead_time_cycles clocks after a change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_req_q <= 1'b0;
            dt_cnt_q   <= 4'h0;
        end else begin
            gate_req_q <= gate_request;
            if (single_line_q && cfg_valid && gate_request != gate_req_q) begin
                dt_cnt_q <= cfg.dead_time_cycles;
            end else if (dt_cnt_q != 4'h0) begin
                dt_cnt_q <= dt_cnt_q - 4'h1;
            end
        end
    end

    // gate outputs; without single-line mode both gates are held off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_high <= 1'b0;
            gate_low  <= 1'b0;
        end else if (!single_line_q || !cfg_valid) begin
            gate_high <= 1'b0;
            gate_low  <= 1'b0;
        end else begin
            // counter at one releases the gate, so the gap is dead_time_cycles clocks, one clock when the count is zero
            gate_high <= gate_request && dt_cnt_q <= 4'h1 && gate_request == gate_req_q;
            gate_low  <= !gate_request && dt_cnt_q <= 4'h1 && gate_request == gate_req_q;
        end
    end

    // bus response, zero-wait, always okay
    always_comb begin
        hreadyout = 1'b1;
        hresp     = 1'b0;
    end

    // read data launched in the address phase, so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == odm_pkg::HTRANS_NONSEQ && !hwrite) begin
            case (haddr)
                odm_pkg::ADDR_FUSE_READBACK * odm_pkg::ADDR_BYTE_SCALE: hrdata <= {24'h0, fuse_q};
                odm_pkg::ADDR_DRIVE_CFG:   hrdata <= {15'h0, cfg};
                odm_pkg::ADDR_SINGLE_LINE: hrdata <= {31'h0, single_line_q};
                odm_pkg::ADDR_DEAD_STATUS: hrdata <= {27'h0, cfg_valid, dt_cnt_q};
                default:                   hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // trim default copied from the fuses on the load edge
    a_load_after_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cfg_valid) |-> cfg.oscillator_trim_code == fuse_q[4:0])
        else $error("trim not loaded from fuses");

    // blank dead-time code maps to four clocks
    a_dead_code_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cfg_valid) && $past(fuse_q[7:6]) == 2'h0 |-> cfg.dead_time_cycles == 4'h4)
        else $error("dead time code zero not four");

    // both short detectors share one fuse bit
    a_short_levels: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cfg_valid) |-> cfg.highside_ground_fault_level == (fuse_q[5] ? 4'hc : 4'h6))
        else $error("short level default wrong");
    a_lowside_level: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(cfg_valid) |-> cfg.lowside_supply_fault_level == (fuse_q[5] ? 4'hc : 4'h6))
        else $error("lowside short level default wrong");

    // shoot-through guard
    a_no_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
        !(gate_high && gate_low))
        else $error("gates overlap");

    // a one-clock gap is always there from the gate_req_q compare, so only longer ones are checked
    a_gap_after_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        single_line_q && cfg_valid && $changed(gate_request) && cfg.dead_time_cycles > 4'h1
        |=> ##1 !gate_high && !gate_low)
        else $error("no dead time after edge");

    // the gap must not outlast the programmed count
    a_dead_gap_ends: assert property (@(posedge hclk) disable iff (!hresetn)
        single_line_q && cfg_valid && dt_cnt_q == 4'h1 && gate_request == gate_req_q
        |=> gate_high || gate_low)
        else $error("dead time too long");

    // separate-input mode never drives the gates from this path
    a_no_gate_double: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(single_line_q) |-> !gate_high && !gate_low)
        else $error("gate driven outside single-line mode");

    // readback shows the fuses as they stood in the address phase
    a_readback_word: assert property (@(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans == 2'h2 && !hwrite && haddr == 32'h14 |=> hrdata == {24'h0, $past(fuse_q)})
        else $error("fuse readback mismatch");

    // a write to the readback word burns nothing
    a_readback_ro: assert property (@(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans == 2'h2 && hwrite && haddr == 32'h14 |=> ##1 fuse_q == $past(fuse_q))
        else $error("readback write changed fuses");

    // programming ors the mask into the cells
    a_prog_sets_only: assert property (@(posedge hclk) disable iff (!hresetn)
        prog_en |=> fuse_q == ($past(fuse_q) | $past(prog_mask)))
        else $error("programming result wrong");
endmodule : odm_top

// ### odm_top_bench.sv
// self-checking bench for the fuse default memory block
`timescale 1ns/1ps
module odm_top_bench;
    localparam logic [4:0] TRIM      = 5'h0b; // arbitrary factory trim
    localparam logic [7:0] MASKS [4] = '{8'h00, 8'h80, 8'h20, 8'h40};
    logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic              gate_request, gate_high, gate_low, cfg_valid, dph_q;
    logic [31:0]       haddr, hwdata, hrdata, rnd_q;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [7:0]        fuse_m, mask;
    int                n_fail, n_checks, cycles, cnt;
    logic [31:0]       exp_q [$];
    odm_pkg::odm_cfg_t cfg;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    odm_top #(.FACTORY_TRIM(TRIM)) i_odm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gate_request(gate_request), .gate_high(gate_high),
        .gate_low(gate_low), .cfg(cfg), .cfg_valid(cfg_valid));

    // 40 mhz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // defaults the fuse byte should load at reset
    function automatic odm_pkg::odm_cfg_t exp_cfg(input logic [7:0] f);
        exp_cfg.dead_time_cycles            = (f[7:6] == 2'h0) ? 4'h4 : {2'h0, f[7:6]};
        exp_cfg.highside_ground_fault_level = f[5] ? 4'hc : 4'h6;
        exp_cfg.lowside_supply_fault_level  = f[5] ? 4'hc : 4'h6;
        exp_cfg.oscillator_trim_code        = f[4:0];
    endfunction : exp_cfg

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // one single transfer; address phase held until ready, then data phase
    task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] data);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= odm_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(addr, 1'b0, 32'h0);
    endtask : rd

    // fuses are nonvolatile, so a reset must not clear them
    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        check({31'h0, cfg_valid}, 32'h1);
        check({15'h0, cfg}, {15'h0, exp_cfg(fuse_m)});
    endtask : do_reset

    // watcher: each read data phase takes the oldest expectation
    always @(posedge hclk) begin
        if (dph_q && hreadyout === 1'b1) check(hrdata, exp_q.pop_front());
        if (dph_q && hreadyout === 1'b1) check({31'h0, hresp}, 32'h0);
        dph_q <= hsel && htrans == odm_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
    end

    // hang guard, far above the roughly 130 cycles needed
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, gate_request} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        {n_fail, n_checks, cycles} = 96'h0;
        rnd_q = 32'h1ae4;
        fuse_m = {3'h0, TRIM};
        do_reset();
        rd(32'h14, {24'h0, fuse_m});
        rd(32'h40, 32'h0);
        // gates stay off while single-line control is not selected
        gate_request <= 1'b1;
        repeat (4) @(posedge hclk);
        #1 check({30'h0, gate_high, gate_low}, 32'h0);
        // set bits one pass at a time; table passes reload defaults by reset
        for (int i = 0; i < 7; i++) begin
            rnd_q = xorshift(rnd_q);
            mask = (i < 4) ? MASKS[i] : (rnd_q[7:0] & 8'he0);
            bus(32'h10, 1'b1, {rnd_q[31:8], mask});
            fuse_m |= mask;
            rd(32'h14, {24'h0, fuse_m});
            if (i < 4) do_reset();
        end
        rd(32'h14, {24'h0, fuse_m});
        // single-line mode: dead time code 3 keeps both gates off for three clocks
        bus(32'h18, 1'b1, 32'h1);
        gate_request <= 1'b0;
        repeat (8) @(posedge hclk);
        #1 check({30'h0, gate_high, gate_low}, 32'h1);
        @(posedge hclk);
        gate_request <= 1'b1;
        cnt = 0;
        repeat (12) begin
            @(posedge hclk);
            #1 if (gate_high === 1'b0 && gate_low === 1'b0) cnt++;
        end
        check({30'h0, gate_high, gate_low}, 32'h2);
        check(cnt, 32'd3);
        rd(32'h1c, 32'h0000_0010);
        bus(32'h14, 1'b1, 32'h0000_00ff);
        rd(32'h14, {24'h0, fuse_m});
        rnd_q = xorshift(rnd_q);
        bus(32'h20, 1'b1, rnd_q);
        rd(32'h20, {15'h0, rnd_q[16:0]});
        // let the watcher take the last data phase before the verdict
        repeat (2) @(posedge hclk);
        results();
    end
endmodule : odm_top_bench
